//--- verilog/spsr_pkg.sv
// Constants shared by the serial port status report block.
// Assumes a 32-bit register port with word-aligned byte offsets.
package spsr_pkg;
  // Register offsets
  localparam logic [7:0] SPSR_ADDR_COUNT  = 8'h00;
  localparam logic [7:0] SPSR_ADDR_QUOTA  = 8'h04;
  localparam logic [7:0] SPSR_ADDR_SPEED  = 8'h08;
  localparam logic [7:0] SPSR_ADDR_CTRL   = 8'h0C;
  // Field positions
  localparam int SPSR_HI_LSB    = 16;
  localparam int SPSR_BQ_LSB    = 8;
  localparam int SPSR_MODES_LSB = 16;
  localparam int SPSR_MODE_LSB  = 4;
  localparam int SPSR_REFL_BIT  = 6;
  localparam int SPSR_FWD_BIT   = 7;
  localparam int SPSR_CLR_BIT   = 0;
  // Reset values and count saturation limit
  localparam logic [15:0] SPSR_ALARM_RST = 16'h0000;
  localparam logic [7:0]  SPSR_QUOTA_RST = 8'h00;
  localparam logic [15:0] SPSR_COUNT_MAX = 16'hFFFF;
  // Cable type codes
  localparam logic [2:0] SPSR_CABLE_NONE = 3'h0;
  localparam logic [2:0] SPSR_CABLE_CU40 = 3'h2;
  localparam logic [2:0] SPSR_CABLE_OP40 = 3'h3;
  // Port mode codes
  localparam logic [1:0] SPSR_MODE_RSVD = 2'h0;
  localparam logic [1:0] SPSR_MODE_WRAP = 2'h1;
  localparam logic [1:0] SPSR_MODE_NORM = 2'h2;
  localparam logic [1:0] SPSR_MODE_PRIV = 2'h3;
  // Speed mask bits
  localparam logic [15:0] SPSR_SPEED_20 = 16'h0001;
  localparam logic [15:0] SPSR_SPEED_40 = 16'h0002;
  localparam logic [15:0] SPSR_SPEED_0  = 16'h0000;
  // Character codes, arbitrary neutral values
  localparam logic [7:0] SPSR_TOKEN_DEF  = 8'hA1;
  localparam logic [7:0] SPSR_TOKENP_DEF = 8'hA2;
endpackage

//--- verilog/spsr_top.sv
// Status record and port mode logic of one loop port.
// Assumes port-side event and status inputs share mclk;
// cable sense pins are asynchronous and are synchronised.
`timescale 1ns/10ps
`default_nettype none
module spsr_top
  import spsr_pkg::*;
#(
  parameter logic [7:0] TOKEN_CODE  = SPSR_TOKEN_DEF,  // Arbitrary value
  parameter logic [7:0] TOKENP_CODE = SPSR_TOKENP_DEF  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // Port events and status
  input  wire logic        recovery_event,
  input  wire logic        total_reset,
  input  wire logic        sup_20,
  input  wire logic        sup_40,
  input  wire logic        run_40,
  input  wire logic        port_operational,
  // Cable sense pins
  input  wire logic        cable_pin_40,
  input  wire logic        cable_pin_optical,
  // Query message
  input  wire logic        query_valid,
  input  wire logic        query_clear,
  output logic             record_valid,
  output logic      [95:0] record_data,
  // Character path
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_user_char,
  output logic             fwd_valid,
  output logic      [7:0]  fwd_char
);

  // Saturating increment, used by the one recovery count path
  // Holds at the top so a long burst cannot wrap to zero
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == SPSR_COUNT_MAX) ? v : v + 16'h0001;
  endfunction

  // Control state
  logic [15:0] count_reg;     // Recovery invocations
  logic [15:0] count_next;
  logic [15:0] alarm_reg;     // Alarm threshold
  logic [7:0]  aquota_reg;    // Static quota
  logic [7:0]  bquota_reg;    // Rotation quota
  logic [1:0]  mode_reg;      // Port mode
  logic        reflect_reg;   // Token reflection
  logic        forward_reg;   // User char forwarding
  logic [1:0]  c40_sync_reg;  // Cable 40 synchroniser
  logic [1:0]  copt_sync_reg; // Cable optical synchroniser

  // Decodes
  // Clear sources: total reset, clearing query, control write
  wire         wr_count = wr_en && (addr == SPSR_ADDR_COUNT);
  wire         wr_quota = wr_en && (addr == SPSR_ADDR_QUOTA);
  wire         wr_ctrl  = wr_en && (addr == SPSR_ADDR_CTRL);
  wire         clr_req  = total_reset || (query_valid && query_clear) ||
                          (wr_ctrl && wr_data[SPSR_CLR_BIT]);
  wire  [1:0]  wr_mode  = wr_data[SPSR_MODES_LSB+SPSR_MODE_LSB +: 2];
  wire         cable_40 = c40_sync_reg[1];
  wire         cable_op = copt_sync_reg[1];
  wire  [2:0]  cable_field;
  wire  [7:0]  modes_byte;
  wire  [15:0] sup_mask;
  wire  [15:0] cur_mask;
  wire  [31:0] word_count;
  wire  [31:0] word_quota;
  wire  [31:0] word_speed;
  wire  [31:0] rd_mux;

  // Count next: clear first, then the event, so a coincident event survives
  // Saturation applies to the cleared value as well, so it never wraps
  always_comb begin
    count_next = clr_req ? 16'h0000 : count_reg;
    if (recovery_event) begin
      count_next = sat_inc(count_next);
    end
  end

  // Cable type from synchronised sense pins
  // A cut link or a 20 MB/s cable has no 40 pin and shows as no information
  assign cable_field = !cable_40 ? SPSR_CABLE_NONE :
                       (cable_op ? SPSR_CABLE_OP40 : SPSR_CABLE_CU40);

  // Modes byte; bit 3 reads zero
  assign modes_byte = {forward_reg, reflect_reg, mode_reg, 1'b0, cable_field};

  // Speed masks
  // Current mask never shows both bits; run_40 picks one
  assign sup_mask = (sup_20 ? SPSR_SPEED_20 : SPSR_SPEED_0) |
                    (sup_40 ? SPSR_SPEED_40 : SPSR_SPEED_0);
  assign cur_mask = !port_operational ? SPSR_SPEED_0 :
                    (run_40 ? SPSR_SPEED_40 : SPSR_SPEED_20);

  // Record words, laid out as the status record
  assign word_count = {alarm_reg, count_reg};
  assign word_quota = {8'h00, modes_byte, bquota_reg, aquota_reg};
  assign word_speed = {cur_mask, sup_mask};

  // Read mux; unmapped offsets read zero
  // Offset 0C is write-only and falls through to zero
  assign rd_mux = (addr == SPSR_ADDR_COUNT) ? word_count :
                  (addr == SPSR_ADDR_QUOTA) ? word_quota :
                  (addr == SPSR_ADDR_SPEED) ? word_speed :
                  32'h0000_0000;

  // Synchronisers for the cable pins
  // Only the second stage is read; the first may still be settling
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      c40_sync_reg  <= 2'h0;
      copt_sync_reg <= 2'h0;
    end else begin
      c40_sync_reg  <= {c40_sync_reg[0], cable_pin_40};
      copt_sync_reg <= {copt_sync_reg[0], cable_pin_optical};
    end
  end

  // Recovery count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_next;
    end
  end

  // Threshold register
  // Shares offset 00 with the read-only count, which writes leave alone
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alarm_reg <= SPSR_ALARM_RST;
    end else if (wr_count) begin
      alarm_reg <= wr_data[SPSR_HI_LSB +: 16];
    end
  end

  // Quotas and mode bits
  // Cable bits and bit 3 are derived, so they are not stored here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aquota_reg  <= SPSR_QUOTA_RST;
      bquota_reg  <= SPSR_QUOTA_RST;
      mode_reg    <= SPSR_MODE_NORM;
      reflect_reg <= 1'b0;
      forward_reg <= 1'b0;
    end else if (wr_quota) begin
      aquota_reg  <= wr_data[7:0];
      bquota_reg  <= wr_data[SPSR_BQ_LSB +: 8];
      // A reserved mode code is ignored so 00b can never be shown
      if (wr_mode != SPSR_MODE_RSVD) begin
        mode_reg <= wr_mode;
      end
      reflect_reg <= wr_data[SPSR_MODES_LSB+SPSR_REFL_BIT];
      forward_reg <= wr_data[SPSR_MODES_LSB+SPSR_FWD_BIT];
    end
  end

  // Read data: only in the cycle after the strobe
  // Zero outside the answer cycle keeps a stale word off the bus
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // Query answer: snapshot taken before any clear of this query
  // Data hold between queries; only the valid pulse marks a new record
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      record_valid <= 1'b0;
      record_data  <= 96'h0;
    end else begin
      record_valid <= query_valid;
      if (query_valid) begin
        record_data <= {word_speed, word_quota, word_count};
      end
    end
  end

  // Character path: token swap and user character filter
  // The character follows every received one, dropped ones included
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fwd_valid <= 1'b0;
      fwd_char  <= 8'h00;
    end else begin
      // Dropped user chars leave a gap; no buffer is kept
      fwd_valid <= rx_valid && (!rx_user_char || forward_reg);
      if (rx_valid) begin
        if (reflect_reg && rx_char == TOKEN_CODE) begin
          fwd_char <= TOKENP_CODE;
        end else if (reflect_reg && rx_char == TOKENP_CODE) begin
          fwd_char <= TOKEN_CODE;
        end else begin
          fwd_char <= rx_char;
        end
      end
    end
  end

  // Checks on the count, registers, record, cable and mode fields, speed masks and character path
  chk_count_saturates: assert property (@(posedge mclk) disable iff (rst)
    (count_reg == SPSR_COUNT_MAX && !clr_req) |=> count_reg == SPSR_COUNT_MAX)
    else $error("recovery count left saturation");

  chk_count_clears: assert property (@(posedge mclk) disable iff (rst)
    (query_valid && query_clear && !recovery_event) |=> count_reg == 16'h0000)
    else $error("recovery count not cleared by query");

  chk_alarm_read: assert property (@(posedge mclk) disable iff (rst)
    (rd_en && addr == SPSR_ADDR_COUNT) |=> rd_data[31:16] == $past(alarm_reg))
    else $error("alarm threshold read mismatch");

  chk_quota_record: assert property (@(posedge mclk) disable iff (rst)
    query_valid |=> record_data[39:32] == $past(aquota_reg))
    else $error("static quota missing from record");

  chk_bquota_write: assert property (@(posedge mclk) disable iff (rst)
    wr_quota |=> bquota_reg == $past(wr_data[SPSR_BQ_LSB +: 8]))
    else $error("rotation quota not written");

  chk_cable_none: assert property (@(posedge mclk) disable iff (rst)
    !cable_40 |-> cable_field == SPSR_CABLE_NONE)
    else $error("cable code without 40 cable");

  chk_cable_optical: assert property (@(posedge mclk) disable iff (rst)
    $rose(copt_sync_reg[1]) && cable_40 |-> modes_byte[2:0] == SPSR_CABLE_OP40)
    else $error("optical cable code wrong");

  chk_mode_legal: assert property (@(posedge mclk) disable iff (rst)
    modes_byte[5:4] != SPSR_MODE_RSVD)
    else $error("reserved port mode shown");

  chk_token_swap: assert property (@(posedge mclk) disable iff (rst)
    (rx_valid && reflect_reg && rx_char == TOKEN_CODE) |=> fwd_char == TOKENP_CODE)
    else $error("token not reflected");

  chk_sup_mask: assert property (@(posedge mclk) disable iff (rst)
    sup_mask == {14'h0, sup_40, sup_20})
    else $error("supported speed mask wrong");

  chk_cur_speed: assert property (@(posedge mclk) disable iff (rst)
    (rd_en && addr == SPSR_ADDR_SPEED && port_operational && run_40)
      |=> rd_data[31:16] == SPSR_SPEED_40)
    else $error("current speed not 40");

  chk_cur_idle: assert property (@(posedge mclk) disable iff (rst)
    !port_operational |-> cur_mask == SPSR_SPEED_0)
    else $error("speed shown while not operational");

  chk_user_drop: assert property (@(posedge mclk) disable iff (rst)
    (rx_valid && rx_user_char && !forward_reg) |=> !fwd_valid)
    else $error("user character forwarded while disabled");

  chk_user_pass: assert property (@(posedge mclk) disable iff (rst)
    (rx_valid && (!rx_user_char || forward_reg)) |=> fwd_valid)
    else $error("character dropped while forwarding allowed");

  // Count arithmetic, the coincident clear, and the total reset and control write clears
  chk_count_step: assert property (@(posedge mclk) disable iff (rst)
    (recovery_event && !clr_req && count_reg != SPSR_COUNT_MAX) |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("recovery count did not step by one");

  chk_clear_event: assert property (@(posedge mclk) disable iff (rst)
    (clr_req && recovery_event) |=> count_reg == 16'h0001)
    else $error("coincident event lost on clear");

  chk_total_clear: assert property (@(posedge mclk) disable iff (rst)
    (total_reset && !recovery_event) |=> count_reg == 16'h0000)
    else $error("recovery count not cleared by total reset");

  chk_ctrl_clear: assert property (@(posedge mclk) disable iff (rst)
    (wr_ctrl && wr_data[SPSR_CLR_BIT] && !recovery_event) |=> count_reg == 16'h0000)
    else $error("recovery count not cleared by register write");

  // Configured fields take the written bytes
  chk_alarm_write: assert property (@(posedge mclk) disable iff (rst)
    wr_count |=> alarm_reg == $past(wr_data[SPSR_HI_LSB +: 16]))
    else $error("alarm threshold not written");

  chk_aquota_write: assert property (@(posedge mclk) disable iff (rst)
    wr_quota |=> aquota_reg == $past(wr_data[7:0]))
    else $error("static quota not written");

  // Cable and mode fields of the modes byte
  chk_cable_copper: assert property (@(posedge mclk) disable iff (rst)
    (cable_40 && !cable_op) |-> cable_field == SPSR_CABLE_CU40)
    else $error("copper cable code wrong");

  chk_mode_hold: assert property (@(posedge mclk) disable iff (rst)
    (wr_quota && wr_mode == SPSR_MODE_RSVD) |=> $stable(mode_reg))
    else $error("reserved mode code taken");

  // Character path in both reflection settings
  chk_primed_swap: assert property (@(posedge mclk) disable iff (rst)
    (rx_valid && reflect_reg && rx_char == TOKENP_CODE) |=> fwd_char == TOKEN_CODE)
    else $error("primed token not reflected");

  chk_no_reflect: assert property (@(posedge mclk) disable iff (rst)
    (rx_valid && !reflect_reg) |=> fwd_char == $past(rx_char))
    else $error("character altered with reflection off");

  // Current speed mask as read back, and its reserved bits
  chk_cur_20: assert property (@(posedge mclk) disable iff (rst)
    (rd_en && addr == SPSR_ADDR_SPEED && port_operational && !run_40) |=> rd_data[31:16] == SPSR_SPEED_20)
    else $error("current speed not 20");

  chk_cur_reserved: assert property (@(posedge mclk) disable iff (rst)
    cur_mask[15:2] == 14'h0000)
    else $error("reserved current speed bit set");

  // Returned record against the state it was taken from
  chk_record_count: assert property (@(posedge mclk) disable iff (rst)
    query_valid |=> record_data[15:0] == $past(count_reg))
    else $error("record count differs from counter");

  chk_record_modes: assert property (@(posedge mclk) disable iff (rst)
    query_valid |=> record_data[53:52] != SPSR_MODE_RSVD)
    else $error("record shows reserved port mode");

  chk_record_speed: assert property (@(posedge mclk) disable iff (rst)
    query_valid |=> record_data[79:64] == {14'h0000, $past(sup_40), $past(sup_20)})
    else $error("record supported speed mask wrong");

endmodule
`default_nettype wire

//--- tb/spsr_host_model.sv
// Host adapter model that issues port status queries.
// Assumes it shares mclk with the block and is driven by task calls.
`timescale 1ns/10ps
`default_nettype none
module spsr_host_model (
  // Clock
  input  wire logic        mclk,
  // Query request
  output logic             query_valid,
  output logic             query_clear,
  // Returned record
  input  wire logic        record_valid,
  input  wire logic [95:0] record_data
);
  // Idle clear level is the inverse of a clearing request
  initial begin
    query_valid = 1'b0;
    query_clear = 1'b0;
  end
  // One query, then take the record in its only valid cycle
  task automatic query(input logic clr, output logic [96:0] rec);
    @(posedge mclk);
    query_valid <= 1'b1;
    query_clear <= clr;
    @(posedge mclk);
    query_valid <= 1'b0;
    query_clear <= ~clr;  // Released line never echoes the request
    #1 rec = {record_valid, record_data};
  endtask
endmodule
`default_nettype wire

//--- tb/serial_port_status_report_tb.sv
// Self-checking bench for the port status record block.
// Assumes the package and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module serial_port_status_report_tb;
  import spsr_pkg::*;
  logic        mclk, rst, wr_en, rd_en;       // Clock, reset, strobes
  logic [7:0]  addr, rx_char, fwd_char;       // Address and characters
  logic [31:0] wr_data, rd_data, qw;          // Register data
  logic        recovery_event, total_reset;   // Port events
  logic        sup_20, sup_40, run_40, port_operational;
  logic        cable_pin_40, cable_pin_optical;
  logic        query_valid, query_clear, record_valid;
  logic [95:0] record_data;                   // Returned record
  logic [96:0] rec;                           // Captured record
  logic        rx_valid, rx_user_char, fwd_valid;
  int          error_cnt, cmp_count, cyc;     // Tallies and watchdog
  spsr_top u_spsr_top (.mclk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .recovery_event, .total_reset, .sup_20, .sup_40, .run_40, .port_operational,
    .cable_pin_40, .cable_pin_optical, .query_valid, .query_clear, .record_valid,
    .record_data, .rx_valid, .rx_char, .rx_user_char, .fwd_valid, .fwd_char);
  spsr_host_model u_spsr_host_model (.mclk, .query_valid, .query_clear,
    .record_valid, .record_data);
  // Free-running 20 MHz clock
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  // Verdict, reached from the main sequence or the watchdog
  task automatic summarize;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Word compare
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Forwarded character compare, valid flag on top
  task automatic chk_c(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  // Read; data only stand in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 chk_w(rd_data, exp);
  endtask
  // Recovery invocations, one per cycle
  task automatic ev(input int n);
    @(posedge mclk);
    recovery_event <= 1'b1;
    repeat (n) @(posedge mclk);
    recovery_event <= 1'b0;
  endtask
  // One received character, forwarded one cycle later
  task automatic chr(input logic [7:0] c, input logic u, input logic [8:0] exp);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_char <= c;
    rx_user_char <= u;
    @(posedge mclk);
    rx_valid <= 1'b0;
    #1 chk_c({fwd_valid, fwd_char}, exp);
  endtask
  // Watchdog sized above the saturation run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    {rst, wr_en, rd_en, addr, wr_data, recovery_event, total_reset} = '0;
    {sup_20, sup_40, run_40, port_operational, cable_pin_40} = '0;
    {cable_pin_optical, rx_valid, rx_char, rx_user_char} = '0;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdc(SPSR_ADDR_COUNT, 32'h0000_0000);
    rdc(SPSR_ADDR_QUOTA, 32'h0020_0000);
    rdc(8'h10, 32'h0000_0000);
    wr(SPSR_ADDR_COUNT, 32'h1234_5678);
    ev(3);
    rdc(SPSR_ADDR_COUNT, 32'h1234_0003);
    wr(SPSR_ADDR_QUOTA, 32'hFFD7_C35A);
    rdc(SPSR_ADDR_QUOTA, 32'h00D0_C35A);
    wr(SPSR_ADDR_QUOTA, 32'h00C0_C35A);   // Reserved mode code is refused
    rdc(SPSR_ADDR_QUOTA, 32'h00D0_C35A);
    chr(SPSR_TOKEN_DEF, 1'b0, {1'b1, SPSR_TOKENP_DEF});
    chr(SPSR_TOKENP_DEF, 1'b0, {1'b1, SPSR_TOKEN_DEF});
    chr(8'h55, 1'b1, 9'h155);
    wr(SPSR_ADDR_QUOTA, 32'h0020_C35A);
    chr(SPSR_TOKEN_DEF, 1'b0, {1'b1, SPSR_TOKEN_DEF});
    chr(8'h55, 1'b1, 9'h055);
    for (int m = 1; m < 4; m++) begin
      qw = {10'h000, m[1:0], 20'hC35A};
      wr(SPSR_ADDR_QUOTA, qw);
      rdc(SPSR_ADDR_QUOTA, qw);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      cable_pin_40 <= (k != 0);
      cable_pin_optical <= (k == 2);
      repeat (3) @(posedge mclk);
      qw = (k == 0) ? 32'h0 : 32'(k + 1) << 16;
      rdc(SPSR_ADDR_QUOTA, 32'h0030_C35A | qw);
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      {port_operational, run_40, sup_40, sup_20} <= 4'(i);
      qw = i[3] ? (i[2] ? 32'h0002_0000 : 32'h0001_0000) : 32'h0;
      rdc(SPSR_ADDR_SPEED, qw | 32'(i[1:0]));
    end
    u_spsr_host_model.query(1'b1, rec);
    chk_w({31'h0, rec[96]}, 32'h1);
    chk_w(rec[31:0], 32'h1234_0003);
    chk_w(rec[63:32], 32'h0033_C35A);
    chk_w(rec[95:64], 32'h0002_0003);
    rdc(SPSR_ADDR_COUNT, 32'h1234_0000);
    ev(2);
    @(posedge mclk);
    total_reset <= 1'b1;
    @(posedge mclk);
    total_reset <= 1'b0;
    rdc(SPSR_ADDR_COUNT, 32'h1234_0000);
    ev(2);
    wr(SPSR_ADDR_CTRL, 32'h0000_0001);
    rdc(SPSR_ADDR_COUNT, 32'h1234_0000);
    rdc(SPSR_ADDR_CTRL, 32'h0000_0000);
    @(posedge mclk);
    total_reset <= 1'b1;
    recovery_event <= 1'b1;
    @(posedge mclk);
    total_reset <= 1'b0;
    recovery_event <= 1'b0;
    rdc(SPSR_ADDR_COUNT, 32'h1234_0001);
    ev(65537);
    rdc(SPSR_ADDR_COUNT, 32'h1234_FFFF);
    u_spsr_host_model.query(1'b0, rec);
    chk_w(rec[31:0], 32'h1234_FFFF);
    rdc(SPSR_ADDR_COUNT, 32'h1234_FFFF);
    summarize();
  end
endmodule
`default_nettype wire
